// [hw/mdio_phy_management_master.sv]
// management data master: register windows to serial phy frames
// Operation
// - every frame opens with 32 one bits
// - indirect frames send start field 00
// - indirect opcodes: 00 address, 01 write, 11 read
// - port address five bits, msb first
// - device address five bits, msb first
// - read turnaround: release first, slave drives zero
// - address and write turnaround driven one, zero
// - sixteen payload bits, bit 15 first
// - line released between accesses; the indirect data frame follows its address frame with the line still driven
// - phy registers reachable through register space
// - direct window access runs one phy frame
// - indirect target select: address, port, device
// - indirect data window accesses selected register
// - no post-read-increment frames ever issued
// - mdc divided from register bus clock
// - mdc never faster than 2.5 MHz with the default HALF_CYCLES
// - frame bits transferred on mdc rising edge
// - direct frames send start field 01
// - direct opcodes: 10 read, 01 write
`timescale 1ns/1ps
module mdio_phy_management_master
  import mdio_mgmt_pkg::*;
#(
  parameter bit USE_CLAUSE45 = 1'b1,
  parameter int HALF_CYCLES  = MDC_HALF_CYCLES
) (
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic [REG_ADDR_W-1:0] reg_addr_in,
  input  wire logic                  reg_read_in,
  input  wire logic                  reg_write_in,
  input  wire logic [31:0]           reg_wdata_in,
  output logic      [31:0]           reg_rdata_out,
  output logic                       reg_wait_out,
  output logic                       mdc_out,
  input  wire logic                  mdio_in,
  output logic                       mdio_out,
  output logic                       mdio_oe_out
);

  typedef enum logic [1:0] {IDLE, FRAME, ACK} mgmt_state_e;

  mgmt_state_e state;
  mgmt_state_e next_state;
  logic [63:0] frame_sr;
  logic [63:0] next_frame_sr;
  logic [5:0]  bit_idx;
  logic [5:0]  next_bit_idx;
  logic        rd_frame;
  logic        next_rd_frame;
  logic        second;
  logic        next_second;
  logic        acc_write;
  logic        next_acc_write;
  logic [15:0] acc_data;
  logic [15:0] next_acc_data;
  logic [15:0] rx_sr;
  logic [15:0] next_rx_sr;
  logic [31:0] mgmt_target_select;
  logic [31:0] next_target;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        next_mdio;
  logic        next_oe;
  logic        mdio_q;
  logic        oe_q;
  logic        mdc_rise;
  logic        mdc_fall;
  logic        req;
  logic        hit_target;
  logic        hit_direct;
  logic        hit_indirect;
  logic [4:0]  direct_regad;
  logic [4:0]  tgt_port;
  logic [4:0]  tgt_dev;

  // frame assembly: preamble, start, opcode, two address fields, turnaround, payload
  function automatic logic [63:0] build_frame(input logic [1:0]  st,
                                              input logic [1:0]  op,
                                              input logic [4:0]  addr1,
                                              input logic [4:0]  addr2,
                                              input logic [1:0]  ta,
                                              input logic [15:0] payload);
    return {PREAMBLE, st, op, addr1, addr2, ta, payload};
  endfunction : build_frame

  mdc_divider #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_mdc_divider (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (state == FRAME),
    .mdc_out    (mdc_out),
    .rise_out   (mdc_rise),
    .fall_out   (mdc_fall)
  );

  // register window decode
  always_comb begin
    req          = reg_read_in || reg_write_in;
    hit_target   = (reg_addr_in == OFS_TARGET);
    hit_direct   = !USE_CLAUSE45 && (reg_addr_in >= OFS_DIRECT_BASE)
                   && (reg_addr_in <= OFS_DIRECT_LAST) && (reg_addr_in[1:0] == 2'b00);
    hit_indirect = USE_CLAUSE45 && (reg_addr_in == OFS_INDIRECT);
    direct_regad = 5'((reg_addr_in - OFS_DIRECT_BASE) >> 2);
    tgt_port     = mgmt_target_select[TGT_PRTAD_LSB +: 5];
    tgt_dev      = USE_CLAUSE45 ? mgmt_target_select[TGT_DEVAD_LSB +: 5]
                                : mgmt_target_select[TGT_PHYAD_LSB +: 5];
  end

  // access sequencing and frame shifting
  always_comb begin
    next_state     = state;
    next_frame_sr  = frame_sr;
    next_bit_idx   = bit_idx;
    next_rd_frame  = rd_frame;
    next_second    = second;
    next_acc_write = acc_write;
    next_acc_data  = acc_data;
    next_rx_sr     = rx_sr;
    next_target    = mgmt_target_select;
    next_rdata     = rdata;
    unique case (state)
      IDLE: begin
        if (req) begin
          next_acc_write = reg_write_in;
          next_acc_data  = reg_wdata_in[15:0];
          next_bit_idx   = IDX_FIRST;
          if (hit_target) begin
            if (reg_write_in) begin
              next_target = reg_wdata_in;
            end
            next_rdata = mgmt_target_select;
            next_state = ACK;
          end else if (hit_direct) begin
            next_frame_sr = build_frame(ST_C22,
                                        reg_write_in ? OP_C22_WRITE : OP_C22_READ,
                                        tgt_dev, direct_regad,
                                        reg_write_in ? TA_DRIVEN : TA_RELEASED,
                                        reg_wdata_in[15:0]);
            next_rd_frame = !reg_write_in;
            next_second   = 1'b0;
            next_state    = FRAME;
          end else if (hit_indirect) begin
            next_frame_sr = build_frame(ST_C45, OP_C45_ADDR, tgt_port, tgt_dev,
                                        TA_DRIVEN,
                                        mgmt_target_select[TGT_REGADDR_LSB +: 16]);
            next_rd_frame = 1'b0;
            next_second   = 1'b1;
            next_state    = FRAME;
          end else begin
            next_rdata = 32'h0000_0000;
            next_state = ACK;
          end
        end
      end
      FRAME: begin
        if (mdc_rise && rd_frame && (bit_idx <= IDX_DATA_MSB)) begin
          next_rx_sr = {rx_sr[14:0], mdio_in};
        end
        if (mdc_fall) begin
          if (bit_idx != 6'd0) begin
            next_frame_sr = {frame_sr[62:0], 1'b0};
            next_bit_idx  = bit_idx - 6'd1;
          end else if (second) begin
            next_frame_sr = build_frame(ST_C45,
                                        acc_write ? OP_C45_WRITE : OP_C45_READ,
                                        tgt_port, tgt_dev,
                                        acc_write ? TA_DRIVEN : TA_RELEASED, acc_data);
            next_bit_idx  = IDX_FIRST;
            next_rd_frame = !acc_write;
            next_second   = 1'b0;
          end else begin
            next_rdata = rd_frame ? {16'h0000, rx_sr} : 32'h0000_0000;
            next_state = ACK;
          end
        end
      end
      ACK: begin
        next_state = IDLE;
      end
    endcase
  end

  // pin drive: released while idle and on the read turnaround and data
  always_comb begin
    next_mdio = (next_state == FRAME) ? next_frame_sr[63] : 1'b1;
    next_oe   = (next_state == FRAME)
                && !(next_rd_frame && (next_bit_idx <= IDX_TA_FIRST));
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state              <= IDLE;
      frame_sr           <= '0;
      bit_idx            <= '0;
      rd_frame           <= 1'b0;
      second             <= 1'b0;
      acc_write          <= 1'b0;
      acc_data           <= '0;
      rx_sr              <= '0;
      mgmt_target_select <= TARGET_RESET;
      rdata              <= '0;
      mdio_q             <= 1'b1;
      oe_q               <= 1'b0;
    end else begin
      state              <= next_state;
      frame_sr           <= next_frame_sr;
      bit_idx            <= next_bit_idx;
      rd_frame           <= next_rd_frame;
      second             <= next_second;
      acc_write          <= next_acc_write;
      acc_data           <= next_acc_data;
      rx_sr              <= next_rx_sr;
      mgmt_target_select <= next_target;
      rdata              <= next_rdata;
      mdio_q             <= next_mdio;
      oe_q               <= next_oe;
    end
  end

  assign reg_rdata_out = rdata;
  assign reg_wait_out  = req && (state != ACK);
  assign mdio_out      = mdio_q;
  assign mdio_oe_out   = oe_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  preamble_ones_a: assert property (
    (state == FRAME) && (bit_idx >= 6'(PREAMBLE_BITS)) |-> mdio_oe_out && mdio_out)
    else $error("preamble bit not driven high");

  start_field_a: assert property (
    (state == FRAME) && (bit_idx == IDX_ST_LO)
    |-> mdio_oe_out && (mdio_out == (USE_CLAUSE45 ? ST_C45[0] : ST_C22[0])))
    else $error("start field low bit wrong");

  start_high_a: assert property (
    (state == FRAME) && (bit_idx == IDX_ST_HI) |-> mdio_oe_out && !mdio_out)
    else $error("start field high bit wrong");

  addr_opcode_a: assert property (
    (state == FRAME) && second && (bit_idx == IDX_OP_HI || bit_idx == IDX_OP_LO)
    |-> !mdio_out)
    else $error("address frame opcode not 00");

  direct_opcode_a: assert property (
    !USE_CLAUSE45 && (state == FRAME) && (bit_idx == IDX_OP_HI) |-> mdio_out == rd_frame)
    else $error("direct opcode high bit wrong");

  port_msb_a: assert property (
    (state == FRAME) && (bit_idx == IDX_ADDR1_MSB)
    |-> mdio_out == (USE_CLAUSE45 ? tgt_port[4] : tgt_dev[4]))
    else $error("first address field not msb first");

  read_release_a: assert property (
    (state == FRAME) && rd_frame && (bit_idx <= IDX_TA_FIRST) |-> !mdio_oe_out)
    else $error("master drives line during read turnaround or data");

  write_ta_a: assert property (
    (state == FRAME) && !rd_frame && (bit_idx == IDX_TA_FIRST) && mdc_fall
    |=> mdio_oe_out && !mdio_out && (bit_idx == IDX_TA_SECOND))
    else $error("driven turnaround not one then zero");

  payload_msb_a: assert property (
    (state == FRAME) && second && (bit_idx == IDX_DATA_MSB)
    |-> mdio_out == mgmt_target_select[31])
    else $error("payload not sent bit 15 first");

  idle_release_a: assert property (
    (state != FRAME) |-> !mdio_oe_out && !mdc_out)
    else $error("line or clock active between frames");

  rise_sample_a: assert property (
    $changed(rx_sr) |-> $past(mdc_rise))
    else $error("read data sampled off the rising edge");

  wait_hold_a: assert property (
    (state == FRAME) && req && !(mdc_fall && (bit_idx == 6'd0) && !second)
    |-> reg_wait_out ##1 (state == FRAME))
    else $error("wait dropped during frame");

  read_return_a: assert property (
    (state == FRAME) && rd_frame && !second && (bit_idx == 6'd0) && mdc_fall
    |=> (state == ACK) && !reg_wait_out && (reg_rdata_out == {16'h0000, rx_sr}))
    else $error("read data not returned at frame end");

  c22_read_c:   cover property (!USE_CLAUSE45 && (state == ACK) && !acc_write
                                && $past(state == FRAME));
  c45_write_c:  cover property (USE_CLAUSE45 && (state == ACK) && acc_write
                                && $past(state == FRAME));
  c45_read_c:   cover property (USE_CLAUSE45 && (state == ACK) && !acc_write
                                && $past(state == FRAME));
  tgt_write_c:  cover property ((state == IDLE) && reg_write_in && hit_target);

endmodule : mdio_phy_management_master

// [hw/mdio_mgmt_pkg.sv]
// constants shared by the management master and its clock divider
package mdio_mgmt_pkg;

  localparam int          REG_ADDR_W      = 10;
  localparam logic [9:0]  OFS_TARGET      = 10'h03c;
  localparam logic [9:0]  OFS_DIRECT_BASE = 10'h200;
  localparam logic [9:0]  OFS_DIRECT_LAST = 10'h27c;
  localparam logic [9:0]  OFS_INDIRECT    = 10'h320;
  localparam logic [31:0] TARGET_RESET    = 32'h0000_0000;

  localparam int          TGT_PHYAD_LSB   = 0;
  localparam int          TGT_DEVAD_LSB   = 0;
  localparam int          TGT_PRTAD_LSB   = 8;
  localparam int          TGT_REGADDR_LSB = 16;

  localparam int          FRAME_BITS      = 64;
  localparam int          PREAMBLE_BITS   = 32;
  localparam logic [5:0]  IDX_FIRST       = 6'd63;
  localparam logic [5:0]  IDX_ST_HI       = 6'd31;
  localparam logic [5:0]  IDX_ST_LO       = 6'd30;
  localparam logic [5:0]  IDX_OP_HI       = 6'd29;
  localparam logic [5:0]  IDX_OP_LO       = 6'd28;
  localparam logic [5:0]  IDX_ADDR1_MSB   = 6'd27;
  localparam logic [5:0]  IDX_TA_FIRST    = 6'd17;
  localparam logic [5:0]  IDX_TA_SECOND   = 6'd16;
  localparam logic [5:0]  IDX_DATA_MSB    = 6'd15;
  localparam logic [31:0] PREAMBLE        = 32'hffff_ffff;

  localparam logic [1:0]  ST_C45          = 2'b00;
  localparam logic [1:0]  ST_C22          = 2'b01;
  localparam logic [1:0]  OP_C45_ADDR     = 2'b00;
  localparam logic [1:0]  OP_C45_WRITE    = 2'b01;
  localparam logic [1:0]  OP_C45_READ     = 2'b11;
  localparam logic [1:0]  OP_C22_READ     = 2'b10;
  localparam logic [1:0]  OP_C22_WRITE    = 2'b01;
  localparam logic [1:0]  TA_DRIVEN       = 2'b10;
  localparam logic [1:0]  TA_RELEASED     = 2'b11;

  localparam int          CLK_KHZ         = 200000;
  localparam int          MDC_MAX_KHZ     = 2500;
  localparam int          MDC_HALF_CYCLES = (CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);

endpackage : mdio_mgmt_pkg

// [hw/mdc_divider.sv]
// management clock divider with rise and fall strobes
`timescale 1ns/1ps
module mdc_divider
  import mdio_mgmt_pkg::*;
#(
  parameter int HALF_CYCLES = MDC_HALF_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic run_in,
  output logic      mdc_out,
  output logic      rise_out,
  output logic      fall_out
);

  localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          mdc;
  logic          next_mdc;
  logic          terminal;

  // mdc is a division of the register clock, held low outside a frame
  always_comb begin
    terminal = (cnt == CW'(HALF_CYCLES - 1));
    next_cnt = cnt;
    next_mdc = mdc;
    if (!run_in) begin
      next_cnt = '0;
      next_mdc = 1'b0;
    end else if (terminal) begin
      next_cnt = '0;
      next_mdc = !mdc;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= '0;
      mdc <= 1'b0;
    end else begin
      cnt <= next_cnt;
      mdc <= next_mdc;
    end
  end

  assign mdc_out  = mdc;
  assign rise_out = run_in && terminal && !mdc;
  assign fall_out = run_in && terminal && mdc;

  mdc_half_period_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $changed(mdc) && mdc |-> $past(cnt) == CW'(HALF_CYCLES - 1))
    else $error("mdc toggled before a full half period");

endmodule : mdc_divider

// [verification/mdio_phy_model.sv]
// behavioural phy device on the management line, one frame clause per instance
`timescale 1ns/1ps
module mdio_phy_model #(
  parameter bit C45 = 1'b1
) (
  input  wire logic mdc_in,
  input  wire logic line_in,
  input  wire logic master_oe_in,
  output logic      oe_out,
  output logic      drv_out
);
  logic [15:0] mem [logic [25:0]];
  logic [31:0] cmd, last_cmd, prev_cmd;
  logic [25:0] k;
  logic [15:0] ptr = 16'h0;
  logic [15:0] rdv;
  int          ones, pos, frames, pre;
  bit          rd, ign, ta_oe;

  function automatic logic [15:0] dflt(input logic [25:0] a);
    return a[15:0] ^ {6'h0, a[25:16]} ^ 16'h5a5a;
  endfunction : dflt

  initial {oe_out, drv_out} = 2'b00;

  always @(posedge mdc_in) begin
    cmd = {cmd[30:0], line_in};
    if (pos != 0) pos++;
    else if (line_in) ones++;
    else if (ones >= 32) pos = 1;
    else ones = 0;
    if (pos == 14) begin
      pre = ones;
      ign = C45 && cmd[13:12] == 2'b01;
      rd  = C45 ? cmd[13:10] == 4'b0011 : cmd[13:10] == 4'b0110;
      k   = C45 ? {cmd[9:0], ptr} : {cmd[9:0], 16'h0};
      rdv = mem.exists(k) ? mem[k] : dflt(k);
    end
    if (pos == 15) ta_oe = master_oe_in;
    if (pos == 32) begin
      frames++;
      prev_cmd = last_cmd;
      last_cmd = cmd;
      pos = 0;
      ones = 0;
      if (!ign && C45 && cmd[29:28] == 2'b00) ptr = cmd[15:0];
      else if (!ign && cmd[29:28] == 2'b01) mem[k] = cmd[15:0];
    end
  end

  always @(negedge mdc_in) begin
    oe_out  <= rd && !ign && pos >= 15 && pos <= 31;
    drv_out <= (pos == 15) ? 1'b0 : rdv[(31 - pos) & 15];
  end
endmodule : mdio_phy_model

// [verification/mdio_phy_management_master_tb_top.sv]
// random and corner-case bench for the management master in both frame clauses
`timescale 1ns/1ps
module mdio_phy_management_master_tb_top;
  import mdio_mgmt_pkg::*;
  localparam int HC  = 2;
  localparam int P22 = 200000 / 2500;
  logic        clk_in, sys_rst_in, rd45, wr45, rd22, wr22, m22d;
  logic        w45, w22, mdc45, mdc22, o45, e45, o22, e22, mo45, me45, mo22, me22;
  logic [9:0]  addr;
  logic [9:0]  ra [4] = '{10'h200, 10'h27c, 10'h320, 10'h100};
  logic [31:0] wdata, q45, q22, q, t;
  logic [31:0] seed = 32'hbf61a339;
  logic [4:0]  p;
  logic [15:0] shadow [logic [25:0]];
  int          n_fail, n_checks, n, f0;
  int          gap = 10000;
  wire logic   l45 = e45 ? o45 : (me45 ? mo45 : 1'b1);
  wire logic   l22 = e22 ? o22 : (me22 ? mo22 : 1'b1);

  mdio_phy_management_master #(.USE_CLAUSE45(1'b1), .HALF_CYCLES(HC)) DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_read_in(rd45),
    .reg_write_in(wr45), .reg_wdata_in(wdata), .reg_rdata_out(q45), .reg_wait_out(w45),
    .mdc_out(mdc45), .mdio_in(l45), .mdio_out(o45), .mdio_oe_out(e45));
  mdio_phy_management_master #(.USE_CLAUSE45(1'b0)) DUT2 (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_read_in(rd22),
    .reg_write_in(wr22), .reg_wdata_in(wdata), .reg_rdata_out(q22), .reg_wait_out(w22),
    .mdc_out(mdc22), .mdio_in(l22), .mdio_out(o22), .mdio_oe_out(e22));
  mdio_phy_model #(.C45(1'b1)) M45 (.mdc_in(mdc45), .line_in(l45), .master_oe_in(e45),
    .oe_out(me45), .drv_out(mo45));
  mdio_phy_model #(.C45(1'b0)) M22 (.mdc_in(mdc22), .line_in(l22), .master_oe_in(e22),
    .oe_out(me22), .drv_out(mo22));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [15:0] expv(input logic [25:0] a);
    return shadow.exists(a) ? shadow[a] : a[15:0] ^ {6'h0, a[25:16]} ^ 16'h5a5a;
  endfunction : expv

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  task automatic acc(input bit c, input bit wr, input logic [9:0] a, input logic [31:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    {rd45, wr45, rd22, wr22} = c ? {!wr, wr, 2'b00} : {2'b00, !wr, wr};
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((c ? w45 : w22) !== 1'b0 && n < 20000);
    q = c ? q45 : q22;
    @(negedge clk_in);
    {rd45, wr45, rd22, wr22} = 4'h0;
    check(32'({e45 | e22, mdc45 | mdc22, l45 & l22}), 32'h1);
  endtask : acc

  task automatic c45_op(input bit wr, input logic [31:0] tg, input logic [15:0] d);
    logic [25:0] k;
    logic [15:0] e;
    k = {tg[12:8], tg[4:0], tg[31:16]};
    e = wr ? d : expv(k);
    acc(1, 1, OFS_TARGET, tg);
    acc(1, 0, OFS_TARGET, 0);
    check(q, tg);
    f0 = M45.frames;
    acc(1, wr, OFS_INDIRECT, (xs() & 32'hffff0000) | {16'h0, d});
    check(32'(M45.frames - f0), 2);
    check(32'(n >= 256 * HC && n <= 256 * HC + 4), 1);
    check(M45.prev_cmd, {4'b0000, tg[12:8], tg[4:0], 2'b10, tg[31:16]});
    check(M45.last_cmd, {2'b00, wr ? 2'b01 : 2'b11, tg[12:8], tg[4:0], 2'b10, e});
    check(32'(M45.ta_oe), 32'(wr));
    check(M45.pre, 32);
    if (wr) shadow[k] = d;
    else check(q, {16'h0, e});
  endtask : c45_op

  task automatic c22_op(input bit wr, input logic [4:0] ph, input logic [4:0] r,
                        input logic [15:0] d);
    logic [25:0] k;
    logic [15:0] e;
    k = {ph, r, 16'h0};
    e = wr ? d : expv(k);
    acc(0, 1, OFS_TARGET, (xs() & 32'hffffffe0) | {27'h0, ph});
    acc(0, 0, OFS_TARGET, 0);
    check(32'(q[4:0]), 32'(ph));
    f0 = M22.frames;
    acc(0, wr, 10'h200 + {3'h0, r, 2'h0}, (xs() & 32'hffff0000) | {16'h0, d});
    check(32'(M22.frames - f0), 1);
    check(32'(n >= 64 * P22 && n <= 64 * P22 + 4), 1);
    check(M22.last_cmd, {2'b01, wr ? 2'b01 : 2'b10, ph, r, 2'b10, e});
    check(32'(M22.ta_oe), 32'(wr));
    check(M22.pre, 32);
    if (wr) shadow[k] = d;
    else check(q, {16'h0, e});
  endtask : c22_op

  always @(posedge clk_in) begin
    m22d <= mdc22;
    gap  <= !w22 ? 10000 : ((mdc22 && !m22d) ? 1 : gap + 1);
    if (mdc22 && !m22d && gap < 1000) check(gap, P22);
  end

  initial begin
    #400000;
    n_fail++;
    results();
  end

  initial begin
    {sys_rst_in, rd45, wr45, rd22, wr22, addr, wdata} = {1'b1, 46'h0};
    repeat (4) @(posedge clk_in);
    check(32'({e45, e22, mdc45, mdc22}), 0);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    acc(1, 0, OFS_TARGET, 0);
    check(q, 0);
    acc(0, 0, OFS_TARGET, 0);
    check(q, 0);
    c45_op(1, 32'hffff1f1f, 16'hffff);
    c45_op(0, 32'hffff1f1f, 0);
    c45_op(1, 0, 0);
    c45_op(0, 0, 0);
    for (int i = 0; i < 6; i++) begin
      t = xs() & 32'hffff1f1f;
      c45_op(1, t, 16'(xs()));
      c45_op(0, t, 0);
      c45_op(0, t ^ 32'h00010000, 0);
    end
    for (int i = 0; i < 4; i++) begin
      f0 = M45.frames + M22.frames;
      acc(i < 2, i[0], ra[i], xs());
      if (!i[0]) check(q, 0);
      check(32'(M45.frames + M22.frames - f0), 0);
    end
    p = 5'(xs());
    c22_op(1, p, 5'h1f, 16'(xs()));
    c22_op(0, p, 5'h1f, 0);
    c22_op(1, 5'h1f, 5'h00, 16'h8001);
    c22_op(0, 5'h1f, 5'h00, 0);
    sys_rst_in = 1'b1;
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    acc(1, 0, OFS_TARGET, 0);
    check(q, 0);
    results();
  end
endmodule : mdio_phy_management_master_tb_top
